// File: hdl/mcc_top.sv
// Main clock controller: CPU prescaler, clock-out, time base and beeper.
//
// The APB interface to the registers and the address map were chosen for this implementation.

// Contract
// - Slow mode divides oscillator by 2, 4, 8 or 16 per prescaler field.
// - Slow select zero gives full-rate CPU clock; prescaler ignored.
// - Bit 7 enables clock-out on its pin; clear leaves pin for GPIO.
// - Clock-out is suspended during active-halt.
// - Time base periods are 16000, 32000, 80000, 200000 oscillator cycles.
// - A new time base takes effect when the running period ends.
// - Flag bit 0 sets each period; any status read clears it.
// - Interrupt requested only if enable set and CPU mask inactive.
// - Halt with interrupt enable set enters active-halt, not halt.
// - In wait the block runs and its interrupt wakes the device; clock-out stops there along with the CPU tick.
// - Active-halt keeps counter running, registers frozen; interrupt wakes.
// - Full halt freezes counter and registers until another wake source.
// - Control/status register resets to all zeros.
// - Beeper drives one of three tones on the beep pin.
// - Beep field: off, about 2 kHz, 1 kHz, 500 Hz at half duty.
module mcc_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cpu_irq_mask,
   input  wire logic        halt_request,
   input  wire logic        wait_request,
   input  wire logic        ext_wake,
   output logic             cpu_clock_tick,
   output logic             time_base_irq,
   output logic             wake_up,
   output logic             clock_out_pin,
   output logic             clock_out_oe,
   output logic             beep_pin,
   output logic             beep_oe,
   output logic [1:0]       power_state
);

   // ----------------------------------------------------------------
   // Registers and bus decode.
   // ----------------------------------------------------------------
   mcc_pkg::mcc_ctrl_t  ctrl;
   logic [1:0]          beep_tone_select;
   mcc_pkg::mcc_power_t pstate;
   logic [17:0]         tb_count;
   logic [17:0]         tb_limit;
   logic [17:0]         next_limit;
   logic                tb_event;
   logic                cpu_tick;
   logic                regs_live;
   logic                wr_en;
   logic                rd_en;
   logic                addr_ok;

   assign regs_live = (pstate == mcc_pkg::MCC_RUN) || (pstate == mcc_pkg::MCC_WAIT);
   assign addr_ok   = (paddr == mcc_pkg::MCC_CTRL_STATUS_OFS)
                   || (paddr == mcc_pkg::MCC_BEEP_CTRL_OFS)
                   || (paddr == mcc_pkg::MCC_POWER_CTRL_OFS);
   assign wr_en     = psel && penable && pwrite && addr_ok && regs_live;
   assign rd_en     = psel && penable && !pwrite;

   always_comb
   begin
      case (ctrl.tb)
         2'b00:   next_limit = mcc_pkg::MCC_TB_PERIOD0;
         2'b01:   next_limit = mcc_pkg::MCC_TB_PERIOD1;
         2'b10:   next_limit = mcc_pkg::MCC_TB_PERIOD2;
         default: next_limit = mcc_pkg::MCC_TB_PERIOD3;
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer: zero wait states, error on unmapped address.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               mcc_pkg::MCC_CTRL_STATUS_OFS: prdata <= {24'h000000, ctrl};
               mcc_pkg::MCC_BEEP_CTRL_OFS:   prdata <= {30'h00000000, beep_tone_select};
               mcc_pkg::MCC_POWER_CTRL_OFS:  prdata <= {30'h00000000, pstate};
               default:                      prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Control/status register.
   // ----------------------------------------------------------------
   // The flag is cleared by any read of this register, so a bit-set or bit-clear from software loses it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= mcc_pkg::MCC_CTRL_RESET;
      end
      else
      begin
         if (wr_en && paddr == mcc_pkg::MCC_CTRL_STATUS_OFS)
         begin
            ctrl.clkout_en <= pwdata[mcc_pkg::MCC_CLKOUT_BIT];
            ctrl.cp        <= pwdata[mcc_pkg::MCC_CP_LSB +: 2];
            ctrl.slow_mode_select       <= pwdata[mcc_pkg::MCC_SMS_BIT];
            ctrl.tb        <= pwdata[mcc_pkg::MCC_TB_LSB +: 2];
            ctrl.time_base_irq_enable       <= pwdata[mcc_pkg::MCC_OIE_BIT];
         end
         // Setting beats a clearing read in the same cycle, so no period is lost.
         if (tb_event)
         begin
            ctrl.flag <= 1'b1;
         end
         else if (rd_en && paddr == mcc_pkg::MCC_CTRL_STATUS_OFS && pready)
         begin
            ctrl.flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         beep_tone_select <= mcc_pkg::MCC_BEEP_RESET[1:0];
      end
      else if (wr_en && paddr == mcc_pkg::MCC_BEEP_CTRL_OFS)
      begin
         beep_tone_select <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Power state sequencing.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pstate <= mcc_pkg::MCC_RUN;
      end
      else
      begin
         case (pstate)
            mcc_pkg::MCC_RUN:
            begin
               if (halt_request)
               begin
                  pstate <= ctrl.time_base_irq_enable ? mcc_pkg::MCC_ACTIVE_HALT : mcc_pkg::MCC_HALT;
               end
               else if (wait_request)
               begin
                  pstate <= mcc_pkg::MCC_WAIT;
               end
            end
            mcc_pkg::MCC_WAIT:
            begin
               if ((tb_event && ctrl.time_base_irq_enable) || ext_wake)
               begin
                  pstate <= mcc_pkg::MCC_RUN;
               end
            end
            mcc_pkg::MCC_ACTIVE_HALT:
            begin
               if ((tb_event && ctrl.time_base_irq_enable) || ext_wake)
               begin
                  pstate <= mcc_pkg::MCC_RUN;
               end
            end
            mcc_pkg::MCC_HALT:
            begin
               if (ext_wake)
               begin
                  pstate <= mcc_pkg::MCC_RUN;
               end
            end
            default:
            begin
               pstate <= mcc_pkg::MCC_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Time base counter.
   // ----------------------------------------------------------------
   // The limit is latched only at period end, so a new setting never shortens a period.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tb_count <= 18'h00000;
         tb_limit <= mcc_pkg::MCC_TB_PERIOD0;
         tb_event <= 1'b0;
      end
      else if (pstate == mcc_pkg::MCC_HALT)
      begin
         tb_event <= 1'b0;
      end
      else if (tb_count >= tb_limit - 18'h00001)
      begin
         tb_count <= 18'h00000;
         tb_limit <= next_limit;
         tb_event <= 1'b1;
      end
      else
      begin
         tb_count <= tb_count + 18'h00001;
         tb_event <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // CPU clock enable, interrupt and clock-out.
   // ----------------------------------------------------------------
   mcc_divider mcc_divider_inst
   (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (pstate == mcc_pkg::MCC_RUN),
      .slow    (ctrl.slow_mode_select),
      .sel     (ctrl.cp),
      .tick    (cpu_tick)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_clock_tick <= 1'b0;
         time_base_irq  <= 1'b0;
         wake_up        <= 1'b0;
         clock_out_pin  <= 1'b0;
         clock_out_oe   <= 1'b0;
         power_state    <= 2'b00;
      end
      else
      begin
         cpu_clock_tick <= cpu_tick;
         time_base_irq  <= ctrl.flag && ctrl.time_base_irq_enable && !cpu_irq_mask;
         wake_up        <= pstate != mcc_pkg::MCC_RUN && pstate != mcc_pkg::MCC_HALT
                           && tb_event && ctrl.time_base_irq_enable;
         clock_out_oe   <= ctrl.clkout_en;
         clock_out_pin  <= ctrl.clkout_en && cpu_tick
                           && pstate != mcc_pkg::MCC_ACTIVE_HALT;
         power_state    <= pstate;
      end
   end

   // ----------------------------------------------------------------
   // Beeper: square wave from a half-period counter.
   // ----------------------------------------------------------------
   // The tone keeps running in active-halt; software must clear the field to save power.
   logic [13:0] beep_limit;

   always_comb
   begin
      beep_limit = {2'b00, mcc_pkg::MCC_BEEP_HALF1} << (beep_tone_select - 2'b01);
   end

   logic [13:0] beep_cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         beep_cnt <= 14'h0000;
         beep_pin <= 1'b0;
         beep_oe  <= 1'b0;
      end
      else if (beep_tone_select == 2'b00 || pstate == mcc_pkg::MCC_HALT)
      begin
         beep_cnt <= 14'h0000;
         beep_pin <= 1'b0;
         beep_oe  <= beep_tone_select != 2'b00;
      end
      else if (beep_cnt >= beep_limit - 14'h0001)
      begin
         beep_cnt <= 14'h0000;
         beep_pin <= !beep_pin;
         beep_oe  <= 1'b1;
      end
      else
      begin
         beep_cnt <= beep_cnt + 14'h0001;
         beep_oe  <= 1'b1;
      end
   end

endmodule

// File: hdl/mcc_pkg.sv
// Package with register map, field layout and timing constants of the clock controller.
package mcc_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses on the APB) and register reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] MCC_CTRL_STATUS_OFS = 8'h00;
   localparam logic [7:0] MCC_BEEP_CTRL_OFS   = 8'h04;
   localparam logic [7:0] MCC_POWER_CTRL_OFS  = 8'h08;
   localparam logic [7:0] MCC_CTRL_RESET      = 8'h00;
   localparam logic [7:0] MCC_BEEP_RESET      = 8'h00;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int MCC_CLKOUT_BIT = 7;
   localparam int MCC_CP_LSB     = 5;
   localparam int MCC_SMS_BIT    = 4;
   localparam int MCC_TB_LSB     = 2;
   localparam int MCC_OIE_BIT    = 1;
   localparam int MCC_FLAG_BIT   = 0;

   // ----------------------------------------------------------------
   // Timing counts in oscillator cycles, with the oscillator and beep frequencies in Hz.
   // ----------------------------------------------------------------
   localparam logic [17:0] MCC_TB_PERIOD0 = 18'd16000;
   localparam logic [17:0] MCC_TB_PERIOD1 = 18'd32000;
   localparam logic [17:0] MCC_TB_PERIOD2 = 18'd80000;
   localparam logic [17:0] MCC_TB_PERIOD3 = 18'd200000;
   localparam int          MCC_OSC_HZ     = 8000000;
   localparam int          MCC_BEEP_HZ1   = 2000;
   localparam logic [11:0] MCC_BEEP_HALF1 = 12'(MCC_OSC_HZ / (2 * MCC_BEEP_HZ1));

   typedef enum logic [1:0] {
      MCC_RUN,
      MCC_WAIT,
      MCC_ACTIVE_HALT,
      MCC_HALT
   } mcc_power_t;

   typedef struct packed {
      logic       clkout_en;
      logic [1:0] cp;
      logic       slow_mode_select;
      logic [1:0] tb;
      logic       time_base_irq_enable;
      logic       flag;
   } mcc_ctrl_t;

endpackage

// File: hdl/mcc_divider.sv
// Programmable power-of-two divider that produces the CPU clock enable.
module mcc_divider
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic       slow,
   input  wire logic [1:0] sel,
   output logic            tick
);

   logic [3:0] count;
   logic [3:0] top;

   always_comb
   begin
      top = 4'((5'h02 << sel) - 5'h01);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= 4'h0;
         tick  <= 1'b0;
      end
      else if (!run)
      begin
         tick <= 1'b0;
      end
      else if (!slow)
      begin
         count <= 4'h0;
         tick  <= 1'b1;
      end
      else if (count >= top)
      begin
         count <= 4'h0;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 4'h1;
         tick  <= 1'b0;
      end
   end

endmodule

// File: test/mcc_monitor.sv
// Concurrent checks on the clock controller ports.
module mcc_monitor
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        cpu_irq_mask,
   input wire logic        halt_request,
   input wire logic        ext_wake,
   input wire logic        cpu_clock_tick,
   input wire logic        time_base_irq,
   input wire logic        clock_out_pin,
   input wire logic        clock_out_oe,
   input wire logic        beep_oe,
   input wire logic [1:0]  power_state
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------
   // Shadow fields
   // ----------
   logic [7:0] sh;
   logic [1:0] bsh;
   logic [4:0] gap;
   logic       chg;
   logic       wr;
   logic       wr_d;
   logic [4:0] div_m1;
   assign wr = psel && penable && pready && pwrite && !power_state[1];
   assign div_m1 = (5'h02 << sh[6:5]) - 5'h01;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {sh, bsh} <= 10'h000;
      else if (wr && paddr == mcc_pkg::MCC_CTRL_STATUS_OFS)
         sh <= pwdata[7:0];
      else if (wr && paddr == mcc_pkg::MCC_BEEP_CTRL_OFS)
         bsh <= pwdata[1:0];
   // Ticks still in the two-stage pipeline at a change, and the first one after it,
   // may come from a partial period, so they are skipped.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {chg, gap, wr_d} <= 7'h40;
      else
      begin
         wr_d <= wr;
         if (wr || wr_d || power_state != 2'h0)
            chg <= 1'b1;
         else if (cpu_clock_tick)
            {chg, gap} <= 6'h00;
         else if (gap != 5'h1F)
            gap <= gap + 5'h01;
      end
   // ----------
   // Assertions
   // ----------
   sequence s_halt;
      halt_request && power_state == mcc_pkg::MCC_RUN;
   endsequence
   full_rate_a: assert property (cpu_clock_tick && !chg && !sh[4] |-> gap == 5'h00)
      else $error("cpu tick not at full rate");
   slow_div_a: assert property (cpu_clock_tick && !chg && sh[4] |-> gap == div_m1)
      else $error("slow divide wrong");
   clkout_oe_a: assert property (clock_out_oe == $past(sh[7]))
      else $error("clock out enable wrong");
   clkout_quiet_a: assert property (power_state == mcc_pkg::MCC_ACTIVE_HALT
      && $past(power_state) == mcc_pkg::MCC_ACTIVE_HALT |-> !clock_out_pin)
      else $error("clock out runs in active halt");
   irq_gate_a: assert property (time_base_irq |-> $past(sh[1]) && !$past(cpu_irq_mask))
      else $error("irq not gated");
   halt_entry_a: assert property (s_halt |-> ##[1:2] power_state ==
      (sh[1] ? mcc_pkg::MCC_ACTIVE_HALT : mcc_pkg::MCC_HALT))
      else $error("wrong halt kind");
   hold_halt_a: assert property (power_state == mcc_pkg::MCC_HALT
      && !ext_wake && !$past(ext_wake) |=> power_state == mcc_pkg::MCC_HALT)
      else $error("left halt alone");
   beep_en_a: assert property (beep_oe == ($past(bsh) != 2'h0))
      else $error("beep enable wrong");
endmodule

// File: test/tb_mcc_top.sv
// Self-checking bench for the clock controller.
module tb_mcc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        cpu_irq_mask = 1'b0;
   logic        halt_request = 1'b0;
   logic        wait_request = 1'b0;
   logic        ext_wake = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, cpu_clock_tick, time_base_irq, wake_up;
   logic        clock_out_pin, clock_out_oe, beep_pin, beep_oe, slv;
   logic [1:0]  power_state;
   logic [31:0] exp_q[$];
   logic [31:0] rs = 32'h626D;
   int          err_total = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          t0, n, k;
   mcc_top mcc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cpu_irq_mask, .halt_request, .wait_request, .ext_wake,
      .cpu_clock_tick, .time_base_irq, .wake_up, .clock_out_pin, .clock_out_oe,
      .beep_pin, .beep_oe, .power_state);
   initial
      forever #20 pclk = ~pclk;
   always @(posedge pclk)
      cyc <= cyc + 1;
   // ----------
   // Tasks
   // ----------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task stop_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e)
      begin
         $display("unexpected at %0t: got %h want %h", $time, got, e);
         err_total++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      slv = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task wait_irq();
      repeat (2) @(posedge pclk);
      k = 0;
      while (time_base_irq !== 1'b1 && k < 17000)
      begin
         @(posedge pclk);
         k++;
      end
   endtask
   task half();
      logic v;
      for (int j = 0; j < 2; j++)
      begin
         v = beep_pin;
         n = 0;
         while (beep_pin === v && n < 9000)
         begin
            @(posedge pclk);
            n++;
         end
      end
   endtask
   task pulse(input int s);
      {halt_request, wait_request, ext_wake} <= 3'(4 >> s);
      repeat (s == 2 ? 2 : 1) @(posedge pclk);
      {halt_request, wait_request, ext_wake} <= 3'h0;
      repeat (3) @(posedge pclk);
   endtask
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         chk(prdata, exp_q.pop_front());
   initial
   begin
      repeat (99000) @(posedge pclk);
      err_total++;
      stop_test();
   end
   // ----------
   // Scenarios
   // ----------
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(mcc_pkg::MCC_CTRL_STATUS_OFS, 32'h0);
      rd(mcc_pkg::MCC_BEEP_CTRL_OFS, 32'h0);
      apb(1'b1, 8'h0C, 32'h0);
      chk(32'(slv), 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         rs = lfsr(rs);
         apb(1'b1, 8'h00, {24'h0, rs[7], i < 4 ? 2'(i) : rs[6:5], 1'(i < 4), 4'h0});
         repeat (32) @(posedge pclk);
         k = 0;
         repeat (64) @(posedge pclk) k += int'(cpu_clock_tick);
         chk(32'(k), i < 4 ? 32'(64 >> (i + 1)) : 32'h40);
         chk(32'(clock_out_oe), 32'(rs[7]));
      end
      rd(8'h00, {24'h0, rs[7:5], 5'h00});
      for (int t = 1; t < 4; t++)
      begin
         apb(1'b1, 8'h04, 32'(t));
         half();
         chk(32'(n), 32'(mcc_pkg::MCC_BEEP_HALF1) << (t - 1));
         chk(32'(beep_oe), 32'h1);
      end
      apb(1'b1, 8'h04, 32'h0);
      cpu_irq_mask <= 1'b1;
      apb(1'b1, 8'h00, 32'h02);
      repeat (17000) @(posedge pclk);
      chk(32'(time_base_irq), 32'h0);
      cpu_irq_mask <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(time_base_irq), 32'h1);
      rd(8'h00, 32'h03);
      rd(8'h00, 32'h02);
      wait_irq();
      t0 = cyc;
      rd(8'h00, 32'h03);
      wait_irq();
      chk(32'(cyc - t0), 32'(mcc_pkg::MCC_TB_PERIOD0));
      t0 = cyc;
      rd(8'h00, 32'h03);
      apb(1'b1, 8'h00, 32'h86);
      pulse(0);
      chk(32'(power_state), 32'(mcc_pkg::MCC_ACTIVE_HALT));
      apb(1'b1, 8'h00, 32'h0);
      k = 0;
      while (wake_up !== 1'b1 && k < 17000)
      begin
         @(posedge pclk);
         k++;
      end
      chk(32'(cyc - t0 > 15990 && cyc - t0 < 16010), 32'h1);
      repeat (3) @(posedge pclk);
      chk(32'(power_state), 32'(mcc_pkg::MCC_RUN));
      rd(8'h00, 32'h87);
      apb(1'b1, 8'h00, 32'h0);
      pulse(0);
      repeat (20) @(posedge pclk);
      chk(32'(power_state), 32'(mcc_pkg::MCC_HALT));
      pulse(2);
      chk(32'(power_state), 32'(mcc_pkg::MCC_RUN));
      pulse(1);
      chk(32'(power_state), 32'(mcc_pkg::MCC_WAIT));
      pulse(2);
      chk(32'(power_state), 32'(mcc_pkg::MCC_RUN));
      stop_test();
   end
endmodule
bind mcc_top mcc_monitor mcc_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .cpu_irq_mask, .halt_request, .ext_wake, .cpu_clock_tick,
   .time_base_irq, .clock_out_pin, .clock_out_oe, .beep_oe, .power_state);
